// File: include/flash_seq_pkg.sv
package flash_seq_pkg;
	// supervisor call keys and parameter block in page 0
	localparam logic [7:0] KEY_MAGIC = 8'h3a;
	localparam logic [7:0] KEY_SP_OFFSET = 8'h03;
	localparam logic [7:0] PB_UNLOCK_CODE_BYTE = 8'hf8;
	localparam logic [7:0] PB_STACK_GUARD_BYTE = 8'hf9;
	localparam logic [7:0] PB_BLOCK = 8'hfa;
	localparam logic [7:0] PB_POINTER = 8'hfb;
	localparam logic [1:0] PARAM_LAST = 2'h3;
	localparam logic [2:0] PARAM_PAGE = 3'h0;
	// command codes
	localparam logic [7:0] CMD_SECTOR_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_SECTOR_CLEAR = 8'h03;
	localparam logic [7:0] CMD_BULK_WIPE = 8'h05;
	localparam logic [7:0] CMD_FACTORY_TABLE = 8'h06;
	localparam logic [7:0] CMD_CHECKSUM = 8'h07;
	localparam logic [7:0] CMD_TRIM_RELOAD = 8'h08;
	// return codes
	localparam logic [7:0] RC_OK = 8'h00;
	localparam logic [7:0] RC_PROTECTED = 8'h01;
	// registers
	localparam logic [7:0] ADDR_READ_PAGE = 8'hd4;
	localparam logic [7:0] ADDR_STATUS = 8'hd6;
	localparam logic [7:0] READ_PAGE_RESET = 8'h00;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_HALT_BIT = 1;
	// flash geometry
	localparam int FLASH_BYTES = 32768;
	localparam int BLOCK_BYTES = 128;
	localparam int PROT_BYTES = 64;
	localparam int TABLE_ENTRIES = 32;
	localparam logic [15:0] BLOCK_LAST = 16'h007f;
	localparam logic [15:0] FILL_END = 16'h0080;
	localparam logic [15:0] BANK_LAST = 16'h7fff;
	localparam logic [2:0] TABLE_LAST = 3'h7;
	localparam logic [1:0] TRIM_TABLE = 2'h1;
	// protection modes
	localparam logic [1:0] MODE_UNPROTECTED = 2'b00;
	localparam logic [1:0] MODE_READ_PROTECT = 2'b01;
	localparam logic [1:0] MODE_NO_OUTSIDE_WRITE = 2'b10;
	localparam logic [1:0] MODE_NO_INSIDE_WRITE = 2'b11;

	typedef enum logic [3:0] {
		S_IDLE, S_PARAM, S_CHECK, S_FILL, S_PROG, S_ERASE, S_BULK, S_SUM, S_TABLE, S_RESULT, S_HALT
	} seq_state_e;
endpackage : flash_seq_pkg

// File: core/flash_block_service_sequencer.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module flash_block_service_sequencer
	import flash_seq_pkg::*;
#(
	// arbitrary neutral contents of the factory tables
	parameter logic [7:0] FACTORY_TABLES [0:TABLE_ENTRIES-1] = '{default: 8'h00}
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic callStart,
	input wire logic [7:0] callAcc,
	input wire logic [7:0] callSp,
	input wire logic externalMode,
	output logic [10:0] sramAddr,
	output logic sramRd,
	output logic sramWr,
	output logic [7:0] sramWrData,
	input wire logic [7:0] sramRdData,
	input wire logic [14:0] tableFetchAddr,
	input wire logic tableFetchRd,
	output logic [7:0] tableFetchData,
	input wire logic protWr,
	input wire logic [5:0] protAddr,
	input wire logic [7:0] protData,
	output logic [7:0] accOut,
	output logic [63:0] trimOut,
	output logic busy,
	output logic done,
	output logic halted
);
	seq_state_e state_q;
	logic [7:0] flashMem [0:FLASH_BYTES-1];
	logic [7:0] protMem [0:PROT_BYTES-1];
	logic [7:0] pageLatch [0:BLOCK_BYTES-1];
	logic [7:0] params_q [0:3];
	logic [15:0] cnt_q;
	logic [7:0] acc_q;
	logic [7:0] sp_q;
	logic [7:0] readPage_q;
	logic [7:0] rdIdx_q;
	logic [7:0] capIdx_q;
	logic rdPend_q;
	logic [15:0] sum_q;
	logic [15:0] sumNext;
	logic [15:0] sumLast;
	logic [7:0] resKey1_q;
	logic [7:0] resKey2_q;
	logic [7:0] accOut_q;
	logic [10:0] sramAddr_q;
	logic sramRd_q;
	logic sramWr_q;
	logic [7:0] sramWrData_q;
	logic [7:0] regRdData_q;
	logic [7:0] tableFetchData_q;
	logic done_q;
	logic [7:0] unlock_code_byte;
	logic [7:0] stack_guard_byte;
	logic [7:0] blockNum;
	logic [7:0] pointer;
	logic [7:0] spPlus;
	logic keysOk;
	logic [7:0] protByte;
	logic [1:0] blockMode;
	logic writeLocked;
	logic [4:0] tableIdx;

	assign unlock_code_byte = params_q[0];
	assign stack_guard_byte = params_q[1];
	assign blockNum = params_q[2];
	assign pointer = params_q[3];
	assign spPlus = sp_q + KEY_SP_OFFSET;
	assign keysOk = (unlock_code_byte == KEY_MAGIC) && (stack_guard_byte == spPlus);
	// block n in low pair, n+3 in top pair
	assign protByte = protMem[blockNum[7:2]];
	assign blockMode = protByte[{blockNum[1:0], 1'b0} +: 2];
	assign writeLocked = externalMode ? blockMode[1] : (blockMode == MODE_NO_INSIDE_WRITE);
	assign sumNext = sum_q + {8'h00, flashMem[cnt_q[14:0]]};
	// zero count covers the whole bank
	assign sumLast = (blockNum == 8'h00) ? BANK_LAST : ({1'b0, blockNum, 7'h00} - 16'h0001);
	assign tableIdx = {blockNum[1:0], cnt_q[2:0]};

	// sequencer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			cnt_q <= 16'h0000;
			acc_q <= 8'h00;
			sp_q <= 8'h00;
			sum_q <= 16'h0000;
			resKey1_q <= 8'h00;
			resKey2_q <= 8'h00;
			accOut_q <= 8'h00;
			sramAddr_q <= 11'h000;
			sramRd_q <= 1'b0;
			sramWr_q <= 1'b0;
			sramWrData_q <= 8'h00;
			rdIdx_q <= 8'h00;
			done_q <= 1'b0;
		end else begin
			sramRd_q <= 1'b0;
			sramWr_q <= 1'b0;
			done_q <= 1'b0;
			unique case (state_q)
				S_IDLE: begin
					if (callStart) begin
						acc_q <= callAcc;
						sp_q <= callSp;
						cnt_q <= 16'h0000;
						state_q <= S_PARAM;
					end
				end
				S_PARAM: begin
					if (cnt_q[2:0] <= {1'b0, PARAM_LAST}) begin
						sramRd_q <= 1'b1;
						sramAddr_q <= {PARAM_PAGE, PB_UNLOCK_CODE_BYTE + cnt_q[7:0]};
						rdIdx_q <= cnt_q[7:0];
						cnt_q <= cnt_q + 16'h0001;
					end
					if (rdPend_q && capIdx_q[1:0] == PARAM_LAST) begin
						state_q <= S_CHECK;
					end
				end
				S_CHECK: begin
					cnt_q <= 16'h0000;
					sum_q <= 16'h0000;
					if (!keysOk) begin
						state_q <= S_HALT;
					end else begin
						unique case (acc_q)
							CMD_SECTOR_PROGRAM, CMD_SECTOR_CLEAR: begin
								if (writeLocked) begin
									resKey1_q <= RC_PROTECTED;
									resKey2_q <= 8'h00;
									accOut_q <= 8'h00;
									state_q <= S_RESULT;
								end else begin
									state_q <= (acc_q == CMD_SECTOR_PROGRAM) ? S_FILL : S_ERASE;
								end
							end
							CMD_BULK_WIPE: state_q <= externalMode ? S_BULK : S_HALT;
							CMD_FACTORY_TABLE: state_q <= S_TABLE;
							CMD_CHECKSUM: state_q <= S_SUM;
							CMD_TRIM_RELOAD: begin
								resKey1_q <= RC_OK;
								resKey2_q <= 8'h00;
								accOut_q <= 8'h00;
								state_q <= S_RESULT;
							end
							default: state_q <= S_HALT;
						endcase
					end
				end
				S_FILL: begin
					if (cnt_q < FILL_END) begin
						sramRd_q <= 1'b1;
						// any page feeds any block
						sramAddr_q <= {readPage_q[2:0], pointer + cnt_q[7:0]};
						rdIdx_q <= cnt_q[7:0];
						cnt_q <= cnt_q + 16'h0001;
					end
					if (rdPend_q && {8'h00, capIdx_q} == BLOCK_LAST) begin
						cnt_q <= 16'h0000;
						state_q <= S_PROG;
					end
				end
				S_PROG, S_ERASE: begin
					cnt_q <= cnt_q + 16'h0001;
					if (cnt_q == BLOCK_LAST) begin
						cnt_q <= 16'h0000;
						resKey1_q <= RC_OK;
						resKey2_q <= 8'h00;
						accOut_q <= 8'h00;
						state_q <= S_RESULT;
					end
				end
				S_BULK: begin
					cnt_q <= cnt_q + 16'h0001;
					if (cnt_q == BANK_LAST) begin
						cnt_q <= 16'h0000;
						resKey1_q <= RC_OK;
						resKey2_q <= 8'h00;
						accOut_q <= 8'h00;
						state_q <= S_RESULT;
					end
				end
				S_SUM: begin
					sum_q <= sumNext;
					cnt_q <= cnt_q + 16'h0001;
					if (cnt_q == sumLast) begin
						cnt_q <= 16'h0000;
						resKey1_q <= sumNext[7:0];
						resKey2_q <= sumNext[15:8];
						accOut_q <= 8'h00;
						state_q <= S_RESULT;
					end
				end
				S_TABLE: begin
					sramWr_q <= 1'b1;
					sramAddr_q <= {PARAM_PAGE, PB_UNLOCK_CODE_BYTE + cnt_q[7:0]};
					sramWrData_q <= FACTORY_TABLES[tableIdx];
					cnt_q <= cnt_q + 16'h0001;
					if (cnt_q[2:0] == TABLE_LAST) begin
						accOut_q <= 8'h00;
						done_q <= 1'b1;
						state_q <= S_IDLE;
					end
				end
				S_RESULT: begin
					cnt_q <= cnt_q + 16'h0001;
					if (cnt_q == 16'h0000) begin
						sramWr_q <= 1'b1;
						sramAddr_q <= {PARAM_PAGE, PB_UNLOCK_CODE_BYTE};
						sramWrData_q <= resKey1_q;
					end else if (cnt_q == 16'h0001) begin
						sramWr_q <= 1'b1;
						sramAddr_q <= {PARAM_PAGE, PB_STACK_GUARD_BYTE};
						sramWrData_q <= resKey2_q;
					end else begin
						done_q <= 1'b1;
						state_q <= S_IDLE;
					end
				end
				S_HALT: state_q <= S_HALT;
				default: state_q <= S_HALT;
			endcase
		end
	end

	// sram read return one cycle after strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdPend_q <= 1'b0;
			capIdx_q <= 8'h00;
		end else begin
			rdPend_q <= sramRd_q;
			capIdx_q <= rdIdx_q;
		end
	end

	// parameter block and page latch capture
	always_ff @(posedge clk) begin
		if (rdPend_q && state_q == S_PARAM) begin
			params_q[capIdx_q[1:0]] <= sramRdData;
		end
		if (rdPend_q && state_q == S_FILL) begin
			pageLatch[capIdx_q[6:0]] <= sramRdData;
		end
	end

	// flash array, nonvolatile so no reset
	always_ff @(posedge clk) begin
		if (state_q == S_PROG) begin
			flashMem[{blockNum, cnt_q[6:0]}] <= pageLatch[cnt_q[6:0]];
		end else if (state_q == S_ERASE) begin
			flashMem[{blockNum, cnt_q[6:0]}] <= 8'h00;
		end else if (state_q == S_BULK) begin
			flashMem[cnt_q[14:0]] <= 8'h00;
		end
	end

	// protection bytes, outside programmer only
	always_ff @(posedge clk) begin
		if (state_q == S_BULK && cnt_q[15:6] == 10'h000) begin
			protMem[cnt_q[5:0]] <= 8'h00;
		end else if (protWr && externalMode && state_q == S_IDLE) begin
			protMem[protAddr] <= protData;
		end
	end

	// table fetch instruction path ignores protection
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tableFetchData_q <= 8'h00;
		end else if (tableFetchRd) begin
			tableFetchData_q <= flashMem[tableFetchAddr];
		end
	end

	// trim destination registers
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_trim
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					trimOut[gi*8 +: 8] <= 8'h00;
				end else if (state_q == S_CHECK && keysOk && acc_q == CMD_TRIM_RELOAD) begin
					trimOut[gi*8 +: 8] <= FACTORY_TABLES[{TRIM_TABLE, 3'(gi)}];
				end
			end
		end
	endgenerate

	// register port
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			readPage_q <= READ_PAGE_RESET;
		end else if (regWr && regAddr == ADDR_READ_PAGE) begin
			readPage_q <= regWrData;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regRdData_q <= 8'h00;
		end else if (regRd) begin
			unique case (regAddr)
				ADDR_READ_PAGE: regRdData_q <= readPage_q;
				ADDR_STATUS: begin
					regRdData_q <= 8'h00;
					regRdData_q[ST_BUSY_BIT] <= (state_q != S_IDLE) && (state_q != S_HALT);
					regRdData_q[ST_HALT_BIT] <= (state_q == S_HALT);
				end
				default: regRdData_q <= 8'h00;
			endcase
		end else begin
			regRdData_q <= 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy <= 1'b0;
			halted <= 1'b0;
		end else begin
			busy <= (state_q != S_IDLE) || callStart;
			halted <= (state_q == S_HALT);
		end
	end

	assign regRdData = regRdData_q;
	assign sramAddr = sramAddr_q;
	assign sramRd = sramRd_q;
	assign sramWr = sramWr_q;
	assign sramWrData = sramWrData_q;
	assign tableFetchData = tableFetchData_q;
	assign accOut = accOut_q;
	assign done = done_q;

	property p_key_halt;
		@(posedge clk) disable iff (!rst_n) (state_q == S_CHECK && !keysOk) |=> (state_q == S_HALT) [*3];
	endproperty
	a_key_halt: assert property (p_key_halt) else $error("bad keys did not halt");

	property p_prot_abort;
		@(posedge clk) disable iff (!rst_n)
			(state_q == S_CHECK && keysOk && acc_q == CMD_SECTOR_PROGRAM && writeLocked)
			|=> state_q == S_RESULT && resKey1_q == RC_PROTECTED && resKey2_q == 8'h00 && accOut_q == 8'h00;
	endproperty
	a_prot_abort: assert property (p_prot_abort) else $error("locked program not aborted");

	property p_clear_abort;
		@(posedge clk) disable iff (!rst_n)
			(state_q == S_CHECK && keysOk && acc_q == CMD_SECTOR_CLEAR && writeLocked)
			|=> ##1 sramWr && sramWrData == RC_PROTECTED;
	endproperty
	a_clear_abort: assert property (p_clear_abort) else $error("locked clear code wrong");

	property p_fill_page;
		@(posedge clk) disable iff (!rst_n) (state_q == S_FILL && sramRd_q) |-> sramAddr_q[10:8] == readPage_q[2:0];
	endproperty
	a_fill_page: assert property (p_fill_page) else $error("fill read from wrong page");

	property p_prog_length;
		@(posedge clk) disable iff (!rst_n) $rose(state_q == S_PROG) |-> ##127 state_q == S_PROG ##1 state_q == S_RESULT;
	endproperty
	a_prog_length: assert property (p_prog_length) else $error("program pass not 128 bytes");

	property p_bulk_inside;
		@(posedge clk) disable iff (!rst_n)
			(state_q == S_CHECK && keysOk && acc_q == CMD_BULK_WIPE && !externalMode) |=> state_q == S_HALT && halted == 1'b0 ##1 halted;
	endproperty
	a_bulk_inside: assert property (p_bulk_inside) else $error("inside bulk wipe not halted");

	property p_sum_report;
		@(posedge clk) disable iff (!rst_n)
			(state_q == S_SUM && cnt_q == sumLast) |=> ##1 sramWr && sramWrData == $past(sumNext[7:0], 2);
	endproperty
	a_sum_report: assert property (p_sum_report) else $error("checksum low byte wrong");

	property p_busy_call;
		@(posedge clk) disable iff (!rst_n) (callStart && state_q == S_IDLE) |=> busy throughout (state_q != S_IDLE)[*2];
	endproperty
	a_busy_call: assert property (p_busy_call) else $error("call not busy");

	property p_table_fetch;
		@(posedge clk) disable iff (!rst_n) tableFetchRd |=> tableFetchData == flashMem[$past(tableFetchAddr)];
	endproperty
	a_table_fetch: assert property (p_table_fetch) else $error("table fetch data wrong");
endmodule : flash_block_service_sequencer

// File: test/sram_model.sv
`timescale 1ns/1ps
module sram_model (
	input wire logic clk,
	input wire logic [10:0] sramAddr,
	input wire logic sramRd,
	input wire logic sramWr,
	input wire logic [7:0] sramWrData,
	output logic [7:0] sramRdData
);
	logic [7:0] mem [0:2047];
	initial sramRdData = 8'h00;
	// read answer one cycle after strobe, stale data inverted otherwise
	always @(posedge clk) begin
		if (sramWr)
			mem[sramAddr] <= sramWrData;
		sramRdData <= sramRd ? mem[sramAddr] : ~sramRdData;
	end
endmodule : sram_model

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
	import flash_seq_pkg::*;
	typedef logic [7:0] tbl_t [0:TABLE_ENTRIES-1];
	function automatic tbl_t mk_tab();
		for (int i = 0; i < TABLE_ENTRIES; i++)
			mk_tab[i] = 8'(i * 7 + 5);
	endfunction : mk_tab
	localparam tbl_t TABS = mk_tab();
	logic clk = 0, rst_n = 0, regWr = 0, regRd = 0, callStart = 0, externalMode = 0;
	logic tableFetchRd = 0, protWr = 0, sramRd, sramWr, busy, done, halted;
	logic [7:0] regAddr = 0, regWrData = 0, regRdData, callAcc = 0, callSp = 0, protData = 0;
	logic [7:0] sramWrData, sramRdData, tableFetchData, accOut, d, rp, p, b, b0;
	logic [10:0] sramAddr;
	logic [14:0] tableFetchAddr = 0;
	logic [5:0] protAddr = 0;
	logic [63:0] trimOut, tx;
	logic [15:0] sa, sb, sum;
	logic [7:0] buf_q [0:127];
	int error_cnt = 0, n_checks = 0, cyc = 0, seed = 32'h8ad3;

	always #25 clk = ~clk;
	flash_block_service_sequencer #(.FACTORY_TABLES(TABS)) dut_u (.clk, .rst_n, .regAddr, .regWrData, .regWr,
		.regRd, .regRdData, .callStart, .callAcc, .callSp, .externalMode, .sramAddr, .sramRd, .sramWr,
		.sramWrData, .sramRdData, .tableFetchAddr, .tableFetchRd, .tableFetchData, .protWr, .protAddr,
		.protData, .accOut, .trimOut, .busy, .done, .halted);
	sram_model su (.clk, .sramAddr, .sramRd, .sramWr, .sramWrData, .sramRdData);

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 95000) begin
			error_cnt++;
			stop_test();
		end
	end
	task automatic do_reset();
		@(posedge clk);
		rst_n <= 0;
		repeat (12) @(posedge clk);
		rst_n <= 1;
	endtask : do_reset
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1;
		@(posedge clk);
		regWr <= 0;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1;
		@(posedge clk);
		regRd <= 0;
		@(negedge clk);
		d = regRdData;
	endtask : reg_rd
	task automatic fetch(input logic [14:0] a);
		@(posedge clk);
		tableFetchAddr <= a;
		tableFetchRd <= 1;
		@(posedge clk);
		tableFetchRd <= 0;
		@(negedge clk);
		d = tableFetchData;
	endtask : fetch
	task automatic prot(input logic ext, input logic [7:0] v);
		@(posedge clk);
		externalMode <= ext;
		protData <= v;
		protWr <= 1;
		@(posedge clk);
		protWr <= 0;
		externalMode <= 0;
	endtask : prot
	function automatic logic [7:0] res(input int i);
		return su.mem[11'(248 + i)];
	endfunction : res
	// parameter block in page 0, keys and stack offset
	task automatic call(input logic [7:0] code, input logic [7:0] k1, input logic [7:0] blk, input logic [7:0] ptr);
		logic [7:0] sp;
		sp = 8'($random(seed));
		su.mem[11'h0f8] = k1;
		su.mem[11'h0f9] = sp + KEY_SP_OFFSET;
		su.mem[11'h0fa] = blk;
		su.mem[11'h0fb] = ptr;
		@(posedge clk);
		callStart <= 1;
		callAcc <= code;
		callSp <= sp;
		@(posedge clk);
		callStart <= 0;
		@(negedge clk);
		chk("busy", 1, busy);
		for (int i = 0; i < 40000 && done !== 1'b1 && halted !== 1'b1; i++)
			@(negedge clk);
		chk("call end", 1, done | halted);
		// last factory table write lands one cycle after done
		@(negedge clk);
	endtask : call
	task automatic fill(input logic [7:0] ptr, input logic rnd);
		sum = 0;
		for (int k = 0; k < 128; k++) begin
			buf_q[k] = rnd ? 8'($random(seed)) : 8'h00;
			su.mem[{rp[2:0], 8'(ptr + k)}] = buf_q[k];
			sum += 16'(buf_q[k]);
		end
	endtask : fill
	task automatic verify(input logic [7:0] blk);
		for (int k = 0; k < 128; k++) begin
			fetch({blk, 7'(k)});
			chk("flash", buf_q[k], d);
		end
	endtask : verify

	initial begin
		do_reset();
		rp = {5'h00, 3'($random(seed)) | 3'h1};
		reg_rd(ADDR_READ_PAGE);
		chk("page reset", READ_PAGE_RESET, d);
		reg_wr(ADDR_READ_PAGE, rp);
		reg_rd(ADDR_READ_PAGE);
		chk("page", rp, d);
		reg_rd(8'h40);
		chk("unmapped", 0, d);
		@(posedge clk);
		externalMode <= 1;
		call(CMD_BULK_WIPE, KEY_MAGIC, 0, 0);
		fetch(15'h0100);
		chk("wiped", 0, d);
		@(posedge clk);
		externalMode <= 0;
		b = 8'($random(seed)) | 8'h02;
		p = 8'($random(seed)) & 8'h7f;
		fill(p, 1);
		sa = sum;
		call(CMD_SECTOR_PROGRAM, KEY_MAGIC, b, p);
		chk("prog rc", RC_OK, res(0));
		verify(b);
		fill(p, 1);
		sb = sum;
		b0 = buf_q[0];
		call(CMD_SECTOR_PROGRAM, KEY_MAGIC, 0, p);
		verify(0);
		call(CMD_CHECKSUM, KEY_MAGIC, 1, 0);
		chk("sum one", sb, {res(1), res(0)});
		call(CMD_CHECKSUM, KEY_MAGIC, 0, 0);
		chk("sum all", 16'(sa + sb), {res(1), res(0)});
		prot(1, 8'h0f);
		prot(0, 8'h00);
		call(CMD_SECTOR_PROGRAM, KEY_MAGIC, 1, p);
		chk("lock rc", RC_PROTECTED, res(0));
		chk("lock stack_guard_byte", 0, res(1));
		chk("lock acc", 0, accOut);
		fetch(15'h0000);
		chk("locked read", b0, d);
		// locked block 1 clear refused, then only block b cleared
		call(CMD_SECTOR_CLEAR, KEY_MAGIC, 1, 0);
		chk("clear lock rc", RC_PROTECTED, res(0));
		call(CMD_SECTOR_CLEAR, KEY_MAGIC, b, 0);
		chk("clear rc", RC_OK, res(0));
		fill(p, 0);
		verify(b);
		for (int t = 0; t < 4; t++) begin
			call(CMD_FACTORY_TABLE, KEY_MAGIC, 8'(t), 0);
			for (int k = 0; k < 8; k++)
				chk("table", TABS[8 * t + k], res(k));
		end
		call(CMD_TRIM_RELOAD, KEY_MAGIC, 0, 0);
		for (int k = 0; k < 8; k++)
			tx[8 * k +: 8] = TABS[8 + k];
		chk("trim", tx, trimOut);
		call(CMD_CHECKSUM, 8'h3b, 1, 0);
		chk("bad key halt", 1, halted);
		reg_rd(ADDR_STATUS);
		chk("status halt", 8'(1 << ST_HALT_BIT), d);
		do_reset();
		call(CMD_BULK_WIPE, KEY_MAGIC, 0, 0);
		chk("inside wipe halt", 1, halted);
		do_reset();
		fetch(15'h0000);
		chk("kept", b0, d);
		stop_test();
	end
endmodule : tb
